// ===== verilog/pmb_consts.vh
// Purpose: shared constants of the management register bank
// Assumes: included by its bare name from the register bank source only
// Notes:   offsets are register numbers on the management bus
// Functional notes
// - addresses 0-8, 14h, 15h, 1Bh, 1Eh, 1Fh are mapped; the gaps are reserved.
// - writing one to control bit 15 starts software reset; bit clears itself.
// - control bit 13 selects 100 or 10 Mbps; strap default; ignored under auto-negotiation.
// - control bit 12 enables auto-negotiation, whose result overrides speed and duplex.
// - control bit 11 selects power-down; resets to zero.
// - control bit 10 isolates the transceiver; default from isolate strap.
// - writing one to control bit 9 restarts auto-negotiation; bit clears itself.
// - control bit 8 selects full duplex; default is inverted duplex strap.
// - control bit 0 disables the transmitter; bits 6 to 1 read zero.
// - status bits 15-11 read 0,1,1,1,1; bits 10 to 7 read zero.
// - status bit 6 reads one: frames without preamble accepted.
// - status bit 5 shows auto-negotiation complete; follows i_an_complete live, not registered.
// - remote fault and jabber latch high; link status latches low; all reset zero.
// - status bits 3 and 0 read one.
// - register 2 reads a fixed 16-bit identifier constant.
// - power-down stops the core but management access keeps working.
`ifndef PMB_CONSTS_VH
`define PMB_CONSTS_VH

`define PMB_ADDR_CTRL       5'h00
`define PMB_ADDR_STATUS     5'h01
`define PMB_ADDR_ID_HIGH    5'h02
`define PMB_ADDR_ID_LOW     5'h03
`define PMB_ADDR_AN_LAST    5'h08
`define PMB_ADDR_IFC_CTRL   5'h14
`define PMB_ADDR_RXERR_CNT  5'h15
`define PMB_ADDR_INT_CS     5'h1B
`define PMB_ADDR_VCTRL1     5'h1E
`define PMB_ADDR_VCTRL2     5'h1F

`define PMB_CTL_RESET       15
`define PMB_CTL_LOOPBACK    14
`define PMB_CTL_SPEED       13
`define PMB_CTL_AN_ENABLE   12
`define PMB_CTL_POWER_DOWN  11
`define PMB_CTL_ISOLATE     10
`define PMB_CTL_AN_RESTART  9
`define PMB_CTL_DUPLEX      8
`define PMB_CTL_COL_TEST    7
`define PMB_CTL_TX_DISABLE  0

`define PMB_STS_FIXED       16'h7849
`define PMB_STS_AN_DONE     5
`define PMB_STS_REM_FAULT   4
`define PMB_STS_LINK        2
`define PMB_STS_JABBER      1

`define PMB_OP_READ         2'h2
`define PMB_OP_WRITE        2'h1
`define PMB_HDR_BITS        5'h0C
`define PMB_BODY_LAST       5'h11

`define PMB_SRST_HOLD       4
`define PMB_RESTART_HOLD    1

`endif

// ===== verilog/pmb_self_clear.v
// Purpose: self-clearing command bit with a hold time
// Assumes: start is a one-cycle strobe from the register write path
// Notes:   active stays high for HOLD cycles, restarts are ignored while busy
`timescale 1ns/1ps
`default_nettype none
module pmb_self_clear #(
  parameter HOLD = 4,
  parameter CW   = 4
) (
  input  wire          i_mclk,
  input  wire          i_arst_n,
  input  wire          i_start,
  output reg           o_active
);
  reg [CW-1:0] cnt_reg;

  // count down from one below the hold value; the bit reads one until the count runs out
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_reg  <= {CW{1'b0}};
      o_active <= 1'b0;
    end else if (i_start && !o_active) begin
      cnt_reg  <= HOLD[CW-1:0] - {{(CW-1){1'b0}}, 1'b1};
      o_active <= 1'b1;
    end else if (o_active) begin
      if (cnt_reg == {CW{1'b0}}) begin
        o_active <= 1'b0;
      end
      cnt_reg <= (cnt_reg == {CW{1'b0}}) ? cnt_reg : cnt_reg - {{(CW-1){1'b0}}, 1'b1};
    end
  end
endmodule
`default_nettype wire

// ===== verilog/pmb_latch_flag.v
// Purpose: status flag that latches high or latches low until read
// Assumes: i_rd pulses in the cycle the register is sampled for a read
// Notes:   a latch-low flag reads zero after reset until the first read
`timescale 1ns/1ps
`default_nettype none
module pmb_latch_flag #(
  parameter LATCH_HIGH = 1
) (
  input  wire          i_mclk,
  input  wire          i_arst_n,
  input  wire          i_level,
  input  wire          i_rd,
  output wire          o_flag
);
  reg  held_reg;
  wire active;

  // work in the latching sense so both polarities share one equation
  assign active = LATCH_HIGH ? i_level : ~i_level;
  assign o_flag = LATCH_HIGH ? held_reg : ~held_reg;

  // an event in the read cycle wins over the clear; after a read follow the live level
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      held_reg <= LATCH_HIGH ? 1'b0 : 1'b1;
    end else if (i_rd) begin
      held_reg <= active;
    end else begin
      held_reg <= held_reg | active;
    end
  end
endmodule
`default_nettype wire

// ===== verilog/pmb_regs.v
// Purpose: management frame slave and basic control/status register bank
// Assumes: mdc and mdio are synchronous to i_mclk and mdc runs well below i_mclk/4
// Notes:   registers outside the basic set are forwarded on the ext port
`timescale 1ns/1ps
`default_nettype none
`include "pmb_consts.vh"
module pmb_regs #(
  parameter [15:0] ID_HIGH     = 16'h1234, // arbitrary identifier value
  parameter        SRST_HOLD   = `PMB_SRST_HOLD,
  parameter        RESTART_HLD = `PMB_RESTART_HOLD
) (
  input  wire        i_mclk,
  input  wire        i_arst_n,
  input  wire [4:0]  i_phy_addr,
  input  wire        i_mdc,
  input  wire        i_mdio,
  output reg         o_mdio,
  output reg         o_mdio_oe,
  input  wire        i_speed_strap,
  input  wire        i_autoneg_enable_strap,
  input  wire        i_isolate_strap,
  input  wire        i_duplex_strap,
  input  wire        i_an_speed_100,
  input  wire        i_an_full_duplex,
  input  wire        i_an_complete,
  input  wire        i_remote_fault,
  input  wire        i_link_up,
  input  wire        i_jabber,
  output reg         o_soft_reset,
  output reg         o_autoneg_restart,
  output reg         o_autoneg_enable,
  output reg         o_loopback,
  output reg         o_speed_100,
  output reg         o_full_duplex,
  output reg         o_power_down,
  output reg         o_core_enable,
  output reg         o_isolate,
  output reg         o_col_test,
  output reg         o_tx_disable,
  output reg         o_ext_wr,
  output reg         o_ext_rd,
  output reg  [4:0]  o_ext_addr,
  output reg  [15:0] o_ext_wdata,
  input  wire [15:0] i_ext_rdata
);
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_START = 3'h1;
  localparam [2:0] ST_HDR   = 3'h2;
  localparam [2:0] ST_BODY  = 3'h3;

  reg  [2:0]  fsm_reg;
  reg  [4:0]  cnt_reg;
  reg  [15:0] shift_reg;
  reg  [15:0] tx_reg;
  reg         mdc_prev_reg;
  reg         bit_prev_reg;
  reg         is_read_reg;
  reg         is_write_reg;
  reg  [4:0]  addr_reg;
  reg         strap_done_reg;
  reg         strap_speed_reg;
  reg         strap_an_reg;
  reg         strap_iso_reg;
  reg         strap_dup_reg;
  reg         ctl_loop_reg;
  reg         ctl_speed_reg;
  reg         ctl_an_reg;
  reg         ctl_pdn_reg;
  reg         ctl_iso_reg;
  reg         ctl_dup_reg;
  reg         ctl_col_reg;
  reg         ctl_txdis_reg;
  reg  [15:0] rdata;
  reg         addr_ext;
  wire        mdc_rise;
  wire [11:0] hdr;
  wire        hdr_done;
  wire        hdr_match;
  wire        rd_strobe;
  wire        wr_strobe;
  wire [15:0] wdata;
  wire        wr_ctrl;
  wire        srst_busy;
  wire        restart_busy;
  wire        def_speed;
  wire        def_an;
  wire        def_iso;
  wire        def_dup;
  wire [2:0]  flag_level;
  wire [2:0]  flag_out;
  wire [15:0] ctrl_word;
  wire [15:0] status_word;

  // frame decode: header bits arrive msb first, the 12th completes it
  assign mdc_rise  = i_mdc & ~mdc_prev_reg;
  assign hdr       = {shift_reg[10:0], i_mdio};
  assign hdr_done  = mdc_rise && (fsm_reg == ST_HDR) && (cnt_reg == `PMB_HDR_BITS - 5'h01);
  assign hdr_match = (hdr[9:5] == i_phy_addr);
  assign rd_strobe = hdr_done && hdr_match && (hdr[11:10] == `PMB_OP_READ);
  assign wr_strobe = mdc_rise && (fsm_reg == ST_BODY) && (cnt_reg == `PMB_BODY_LAST) && is_write_reg;
  assign wdata     = {shift_reg[14:0], i_mdio};
  assign wr_ctrl   = wr_strobe && (addr_reg == `PMB_ADDR_CTRL);

  // mdc edge and last line level, kept across frames for start detection
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mdc_prev_reg <= 1'b0;
      bit_prev_reg <= 1'b1;
    end else begin
      mdc_prev_reg <= i_mdc;
      if (mdc_rise) begin
        bit_prev_reg <= i_mdio;
      end
    end
  end

  // frame state machine; a start needs only one idle bit, so preamble may be absent
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      fsm_reg      <= ST_IDLE;
      cnt_reg      <= 5'h00;
      shift_reg    <= 16'h0000;
      is_read_reg  <= 1'b0;
      is_write_reg <= 1'b0;
      addr_reg     <= 5'h00;
    end else if (mdc_rise) begin
      shift_reg <= {shift_reg[14:0], i_mdio};
      case (fsm_reg)
        ST_IDLE: begin
          if (!i_mdio && bit_prev_reg) begin
            fsm_reg <= ST_START;
          end
        end
        ST_START: begin
          fsm_reg <= i_mdio ? ST_HDR : ST_IDLE;
          cnt_reg <= 5'h00;
        end
        ST_HDR: begin
          if (hdr_done) begin
            fsm_reg      <= ST_BODY;
            cnt_reg      <= 5'h00;
            addr_reg     <= hdr[4:0];
            is_read_reg  <= rd_strobe;
            is_write_reg <= hdr_match && (hdr[11:10] == `PMB_OP_WRITE);
          end else begin
            cnt_reg <= cnt_reg + 5'h01;
          end
        end
        ST_BODY: begin
          if (cnt_reg == `PMB_BODY_LAST) begin
            fsm_reg      <= ST_IDLE;
            is_read_reg  <= 1'b0;
            is_write_reg <= 1'b0;
          end
          cnt_reg <= cnt_reg + 5'h01;
        end
        default: begin
          fsm_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // read turnaround: float for the first bit, drive zero, then 16 data bits
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_mdio    <= 1'b0;
      o_mdio_oe <= 1'b0;
      tx_reg    <= 16'h0000;
    end else if (rd_strobe) begin
      tx_reg    <= rdata;
      o_mdio_oe <= 1'b0;
    end else if (mdc_rise && (fsm_reg == ST_BODY) && is_read_reg) begin
      if (cnt_reg == 5'h00) begin
        o_mdio_oe <= 1'b1;
        o_mdio    <= 1'b0;
      end else if (cnt_reg == `PMB_BODY_LAST) begin
        o_mdio_oe <= 1'b0;
        o_mdio    <= 1'b0;
      end else begin
        o_mdio <= tx_reg[15];
        tx_reg <= {tx_reg[14:0], 1'b0};
      end
    end
  end

  // straps are caught on the first edge after reset release and kept for soft reset
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      strap_done_reg  <= 1'b0;
      strap_speed_reg <= 1'b0;
      strap_an_reg    <= 1'b0;
      strap_iso_reg   <= 1'b0;
      strap_dup_reg   <= 1'b0;
    end else if (!strap_done_reg) begin
      strap_done_reg  <= 1'b1;
      strap_speed_reg <= i_speed_strap;
      strap_an_reg    <= i_autoneg_enable_strap;
      strap_iso_reg   <= i_isolate_strap;
      strap_dup_reg   <= ~i_duplex_strap;
    end
  end

  assign def_speed = strap_done_reg ? strap_speed_reg : i_speed_strap;
  assign def_an    = strap_done_reg ? strap_an_reg : i_autoneg_enable_strap;
  assign def_iso   = strap_done_reg ? strap_iso_reg : i_isolate_strap;
  assign def_dup   = strap_done_reg ? strap_dup_reg : ~i_duplex_strap;

  // software reset holds bit 15 high while the defaults are forced
  pmb_self_clear #(
    .HOLD (SRST_HOLD),
    .CW   (8)
  ) u_srst (
    .i_mclk   (i_mclk),
    .i_arst_n (i_arst_n),
    .i_start  (wr_ctrl && wdata[`PMB_CTL_RESET]),
    .o_active (srst_busy)
  );

  // restart is a short self-clearing command
  pmb_self_clear #(
    .HOLD (RESTART_HLD),
    .CW   (4)
  ) u_restart (
    .i_mclk   (i_mclk),
    .i_arst_n (i_arst_n),
    .i_start  (wr_ctrl && wdata[`PMB_CTL_AN_RESTART] && !wdata[`PMB_CTL_RESET] && !srst_busy),
    .o_active (restart_busy)
  );

  // control fields; a write carrying the reset bit is replaced by the defaults
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctl_loop_reg  <= 1'b0;
      ctl_speed_reg <= 1'b0;
      ctl_an_reg    <= 1'b0;
      ctl_pdn_reg   <= 1'b0;
      ctl_iso_reg   <= 1'b0;
      ctl_dup_reg   <= 1'b0;
      ctl_col_reg   <= 1'b0;
      ctl_txdis_reg <= 1'b0;
    end else if (!strap_done_reg || srst_busy || (wr_ctrl && wdata[`PMB_CTL_RESET])) begin
      ctl_loop_reg  <= 1'b0;
      ctl_speed_reg <= def_speed;
      ctl_an_reg    <= def_an;
      ctl_pdn_reg   <= 1'b0;
      ctl_iso_reg   <= def_iso;
      ctl_dup_reg   <= def_dup;
      ctl_col_reg   <= 1'b0;
      ctl_txdis_reg <= 1'b0;
    end else if (wr_ctrl) begin
      ctl_loop_reg  <= wdata[`PMB_CTL_LOOPBACK];
      ctl_speed_reg <= wdata[`PMB_CTL_SPEED];
      ctl_an_reg    <= wdata[`PMB_CTL_AN_ENABLE];
      ctl_pdn_reg   <= wdata[`PMB_CTL_POWER_DOWN];
      ctl_iso_reg   <= wdata[`PMB_CTL_ISOLATE];
      ctl_dup_reg   <= wdata[`PMB_CTL_DUPLEX];
      ctl_col_reg   <= wdata[`PMB_CTL_COL_TEST];
      ctl_txdis_reg <= wdata[`PMB_CTL_TX_DISABLE];
    end
  end

  // core-facing outputs; the negotiated result wins while auto-negotiation runs
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_soft_reset      <= 1'b0;
      o_autoneg_restart <= 1'b0;
      o_autoneg_enable  <= 1'b0;
      o_loopback        <= 1'b0;
      o_speed_100       <= 1'b0;
      o_full_duplex     <= 1'b0;
      o_power_down      <= 1'b0;
      o_core_enable     <= 1'b0;
      o_isolate         <= 1'b0;
      o_col_test        <= 1'b0;
      o_tx_disable      <= 1'b0;
    end else begin
      o_soft_reset      <= srst_busy;
      o_autoneg_restart <= restart_busy && ctl_an_reg && !ctl_pdn_reg;
      o_autoneg_enable  <= ctl_an_reg;
      o_loopback        <= ctl_loop_reg;
      o_speed_100       <= ctl_an_reg ? i_an_speed_100 : ctl_speed_reg;
      o_full_duplex     <= ctl_an_reg ? i_an_full_duplex : ctl_dup_reg;
      o_power_down      <= ctl_pdn_reg;
      o_core_enable     <= !ctl_pdn_reg && !srst_busy;
      o_isolate         <= ctl_iso_reg;
      o_col_test        <= ctl_col_reg;
      o_tx_disable      <= ctl_txdis_reg;
    end
  end

  // latched status flags: 0 jabber and 2 remote fault latch high, 1 link latches low
  assign flag_level = {i_remote_fault, i_link_up, i_jabber};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_flag
      pmb_latch_flag #(
        .LATCH_HIGH ((gi == 1) ? 0 : 1)
      ) u_flag (
        .i_mclk   (i_mclk),
        .i_arst_n (i_arst_n),
        .i_level  (flag_level[gi]),
        .i_rd     (rd_strobe && (hdr[4:0] == `PMB_ADDR_STATUS)),
        .o_flag   (flag_out[gi])
      );
    end
  endgenerate

  assign ctrl_word = {srst_busy, ctl_loop_reg, ctl_speed_reg, ctl_an_reg,
                      ctl_pdn_reg, ctl_iso_reg, restart_busy, ctl_dup_reg,
                      ctl_col_reg, 6'h00, ctl_txdis_reg};

  assign status_word = `PMB_STS_FIXED
                     | ({15'h0000, i_an_complete} << `PMB_STS_AN_DONE)
                     | ({15'h0000, flag_out[2]} << `PMB_STS_REM_FAULT)
                     | ({15'h0000, flag_out[1]} << `PMB_STS_LINK)
                     | ({15'h0000, flag_out[0]} << `PMB_STS_JABBER);

  // registers beyond the basic set live elsewhere and are only decoded here
  always @* begin
    addr_ext = 1'b0;
    if ((hdr[4:0] >= `PMB_ADDR_ID_LOW) && (hdr[4:0] <= `PMB_ADDR_AN_LAST)) begin
      addr_ext = 1'b1;
    end else if ((hdr[4:0] == `PMB_ADDR_IFC_CTRL) || (hdr[4:0] == `PMB_ADDR_RXERR_CNT)) begin
      addr_ext = 1'b1;
    end else if (hdr[4:0] == `PMB_ADDR_INT_CS) begin
      addr_ext = 1'b1;
    end else if ((hdr[4:0] == `PMB_ADDR_VCTRL1) || (hdr[4:0] == `PMB_ADDR_VCTRL2)) begin
      addr_ext = 1'b1;
    end
  end

  // read data select; reserved addresses answer zero
  always @* begin
    rdata = 16'h0000;
    if (hdr[4:0] == `PMB_ADDR_CTRL) begin
      rdata = ctrl_word;
    end else if (hdr[4:0] == `PMB_ADDR_STATUS) begin
      rdata = status_word;
    end else if (hdr[4:0] == `PMB_ADDR_ID_HIGH) begin
      rdata = ID_HIGH;
    end else if (addr_ext) begin
      rdata = i_ext_rdata;
    end
  end

  // forwarded accesses; the address decode is latched with the header
  reg ext_addr_reg;
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ext_addr_reg <= 1'b0;
      o_ext_wr     <= 1'b0;
      o_ext_rd     <= 1'b0;
      o_ext_addr   <= 5'h00;
      o_ext_wdata  <= 16'h0000;
    end else begin
      if (hdr_done) begin
        ext_addr_reg <= addr_ext;
      end
      o_ext_rd <= rd_strobe && addr_ext;
      o_ext_wr <= wr_strobe && ext_addr_reg;
      if (hdr_done) begin
        o_ext_addr <= hdr[4:0];
      end
      if (wr_strobe && ext_addr_reg) begin
        o_ext_wdata <= wdata;
      end
    end
  end
endmodule
`default_nettype wire

// ===== verif/pmb_regs_monitor.sv
// Purpose: concurrent checks on the ports of the management register bank
// Assumes: single clock domain, asynchronous active-low reset
// Notes:   span of the soft reset is counted in helper logic, not by repetition
`timescale 1ns/1ps
`default_nettype none
module pmb_regs_monitor #(
  parameter SRST_HOLD = 4
) (
  input wire logic       i_mclk,
  input wire logic       i_arst_n,
  input wire logic       i_isolate_strap,
  input wire logic       i_autoneg_enable_strap,
  input wire logic       i_an_speed_100,
  input wire logic       i_an_full_duplex,
  input wire logic       o_mdio,
  input wire logic       o_mdio_oe,
  input wire logic       o_soft_reset,
  input wire logic       o_autoneg_restart,
  input wire logic       o_autoneg_enable,
  input wire logic       o_loopback,
  input wire logic       o_speed_100,
  input wire logic       o_full_duplex,
  input wire logic       o_power_down,
  input wire logic       o_core_enable,
  input wire logic       o_isolate,
  input wire logic       o_col_test,
  input wire logic       o_tx_disable,
  input wire logic       o_ext_wr,
  input wire logic       o_ext_rd,
  input wire logic [4:0] o_ext_addr
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  logic [7:0] hi_cnt;
  logic [2:0] up_reg;
  logic       fwd;
  // high-time counter of soft reset and edges seen since reset release
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      hi_cnt <= 8'h00;
      up_reg <= 3'h0;
    end else begin
      hi_cnt <= o_soft_reset ? hi_cnt + 8'h01 : 8'h00;
      up_reg <= {up_reg[1:0], 1'b1};
    end
  end
  // forwarded addresses; reserved ones must never reach the ext port
  assign fwd = o_ext_addr inside {[5'h03:5'h08], 5'h14, 5'h15, 5'h1B, 5'h1E, 5'h1F};
  a_strap_defaults: assert property (up_reg[1] && !up_reg[2] |-> o_isolate == $past(i_isolate_strap, 2)
    && o_autoneg_enable == $past(i_autoneg_enable_strap, 2) && !o_loopback && !o_power_down && !o_col_test
    && !o_tx_disable) else $error("control outputs differ from defaults after reset");
  a_speed_negotiated: assert property (o_autoneg_enable ##1 o_autoneg_enable |->
    o_speed_100 == $past(i_an_speed_100)) else $error("speed does not follow negotiated result");
  a_duplex_negotiated: assert property (o_autoneg_enable ##1 o_autoneg_enable |->
    o_full_duplex == $past(i_an_full_duplex)) else $error("duplex does not follow negotiated result");
  a_soft_reset_span: assert property ($fell(o_soft_reset) |-> hi_cnt == SRST_HOLD)
    else $error("soft reset span wrong");
  a_restart_one_shot: assert property ($rose(o_autoneg_restart) |=> !o_autoneg_restart)
    else $error("restart pulse too long");
  a_ext_wr_mapped: assert property (o_ext_wr |-> fwd ##1 !o_ext_wr)
    else $error("ext write to unmapped address or too long");
  a_ext_rd_mapped: assert property (o_ext_rd |-> fwd ##1 !o_ext_rd)
    else $error("ext read of unmapped address or too long");
  a_turnaround_zero: assert property ($rose(o_mdio_oe) |-> !o_mdio)
    else $error("turnaround bit not zero");
  a_power_core_off: assert property (o_power_down |-> !o_core_enable)
    else $error("core enabled while powered down");
endmodule
bind pmb_regs pmb_regs_monitor #(.SRST_HOLD(SRST_HOLD)) pmb_regs_monitor_i (.i_mclk, .i_arst_n, .i_isolate_strap,
  .i_autoneg_enable_strap, .i_an_speed_100, .i_an_full_duplex, .o_mdio, .o_mdio_oe, .o_soft_reset,
  .o_autoneg_restart, .o_autoneg_enable, .o_loopback, .o_speed_100, .o_full_duplex, .o_power_down,
  .o_core_enable, .o_isolate, .o_col_test, .o_tx_disable, .o_ext_wr, .o_ext_rd, .o_ext_addr);
`default_nettype wire

// ===== verif/pmb_station.sv
// Purpose: management station model that sends frames to the register bank
// Assumes: the data line has a pull-up; the bank drives only with its enable high
// Notes:   mdc stands low between frames; half is the mdc half period in mclk
`timescale 1ns/1ps
`default_nettype none
module pmb_station (
  input  wire logic i_mclk,
  input  wire logic i_mdio,
  input  wire logic i_mdio_oe,
  output var  logic o_mdc,
  output wire logic o_mdio
);
  logic drv = 1'b0;
  logic val = 1'b1;
  int   half = 4;
  initial o_mdc = 1'b0;
  // wired level: bank first, then station, else the pull-up
  assign o_mdio = i_mdio_oe ? i_mdio : (drv ? val : 1'b1);
  // one frame: idle bit, start, op, addresses, turnaround, data; read data taken before each rise
  task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [32:0] bits;
    bits = {3'b101, op, pa, ra, 2'b10, wd};
    rd = 16'h0000;
    for (int i = 0; i < 33; i++) begin
      @(negedge i_mclk);
      o_mdc = 1'b0;
      drv = !(op == 2'b10 && i > 14);
      val = bits[32-i];
      repeat (half) @(negedge i_mclk);
      if (i > 16) rd = {rd[14:0], o_mdio};
      o_mdc = 1'b1;
      repeat (half - 1) @(negedge i_mclk);
    end
    @(negedge i_mclk);
    o_mdc = 1'b0;
    drv = 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== verif/testbench.sv
// Purpose: self-checking bench for the management register bank
// Assumes: station model sends frames; straps and live levels drawn at random
// Notes:   soft reset hold left at four cycles, identifier value arbitrary
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [15:0] ID = 16'hA5C3; // arbitrary identifier
  logic i_mclk = 1'b0, i_arst_n = 1'b0, i_mdc, i_mdio, o_mdio, o_mdio_oe;
  logic i_speed_strap = 1'b0, i_autoneg_enable_strap = 1'b0, i_isolate_strap = 1'b0, i_duplex_strap = 1'b0;
  logic i_an_speed_100 = 1'b0, i_an_full_duplex = 1'b0, i_an_complete = 1'b0;
  logic i_remote_fault = 1'b0, i_link_up = 1'b0, i_jabber = 1'b0;
  logic o_soft_reset, o_autoneg_restart, o_autoneg_enable, o_loopback, o_speed_100, o_full_duplex;
  logic o_power_down, o_core_enable, o_isolate, o_col_test, o_tx_disable, o_ext_wr, o_ext_rd;
  logic [4:0]  i_phy_addr = 5'h00, o_ext_addr;
  logic [15:0] i_ext_rdata = 16'h0000, o_ext_wdata, w, r;
  logic [4:0]  rsv [6] = '{5'h09, 5'h13, 5'h16, 5'h1A, 5'h1C, 5'h1D};
  logic [4:0]  fwd [8] = '{5'h03, 5'h04, 5'h08, 5'h14, 5'h15, 5'h1B, 5'h1E, 5'h1F};
  int num_errors = 0, check_count = 0, wcnt = 0, rcnt = 0, rscnt = 0, srcnt = 0;
  pmb_regs #(.ID_HIGH(ID), .SRST_HOLD(4)) pmb_regs_i (.i_mclk, .i_arst_n, .i_phy_addr, .i_mdc, .i_mdio,
    .o_mdio, .o_mdio_oe, .i_speed_strap, .i_autoneg_enable_strap, .i_isolate_strap, .i_duplex_strap,
    .i_an_speed_100, .i_an_full_duplex, .i_an_complete, .i_remote_fault, .i_link_up, .i_jabber,
    .o_soft_reset, .o_autoneg_restart, .o_autoneg_enable, .o_loopback, .o_speed_100, .o_full_duplex,
    .o_power_down, .o_core_enable, .o_isolate, .o_col_test, .o_tx_disable, .o_ext_wr, .o_ext_rd,
    .o_ext_addr, .o_ext_wdata, .i_ext_rdata);
  pmb_station pmb_station_i (.i_mclk, .i_mdio(o_mdio), .i_mdio_oe(o_mdio_oe), .o_mdc(i_mdc), .o_mdio(i_mdio));
  initial forever #4 i_mclk = ~i_mclk;
  // pulse outputs are counted here in high cycles since the bench cannot sit on every edge
  always @(posedge i_mclk) begin
    wcnt  <= wcnt + int'(o_ext_wr);
    rcnt  <= rcnt + int'(o_ext_rd);
    rscnt <= rscnt + int'(o_autoneg_restart);
    srcnt <= srcnt + int'(o_soft_reset);
  end
  function automatic logic [15:0] ctl_def();
    return {2'b00, i_speed_strap, i_autoneg_enable_strap, 1'b0, i_isolate_strap, 1'b0, !i_duplex_strap, 8'h00};
  endfunction
  function automatic logic [15:0] sts(input logic f, input logic l, input logic j);
    return 16'h7849 | {10'h000, i_an_complete, f, 1'b0, l, j, 1'b0};
  endfunction
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    pmb_station_i.frame(2'b01, i_phy_addr, ra, d, r);
  endtask
  task automatic rchk(input string what, input logic [4:0] ra, input logic [15:0] e);
    pmb_station_i.frame(2'b10, i_phy_addr, ra, 16'h0000, r);
    chk(what, e, r);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // watchdog sized well above the expected run of about seventeen thousand cycles
  initial begin
    repeat (60000) @(posedge i_mclk);
    num_errors++;
    finish_test;
  end
  initial begin
    r = 16'($urandom(78));
    {i_speed_strap, i_autoneg_enable_strap, i_isolate_strap, i_duplex_strap, i_an_complete} = 5'($urandom);
    i_phy_addr = 5'($urandom);
    repeat (6) @(negedge i_mclk);
    i_arst_n = 1'b1;
    repeat (4) @(negedge i_mclk);
    rchk("control", 5'h00, ctl_def());
    rchk("ident", 5'h02, ID);
    $display("test defaults done");
    i_link_up = 1'b1;
    rchk("status", 5'h01, sts(1'b0, 1'b0, 1'b0));
    rchk("status", 5'h01, sts(1'b0, 1'b1, 1'b0));
    {i_remote_fault, i_jabber, i_link_up} = 3'b110;
    repeat (3) @(negedge i_mclk);
    {i_remote_fault, i_jabber, i_link_up} = 3'b001;
    i_an_complete = ~i_an_complete;
    rchk("status", 5'h01, sts(1'b1, 1'b0, 1'b1));
    rchk("status", 5'h01, sts(1'b0, 1'b1, 1'b0));
    $display("test status done");
    // random control words, with 7DFF and all-zeros as corners and both station speeds
    for (int k = 0; k < 8; k++) begin
      pmb_station_i.half = (k % 2) ? 6 : 2;
      {i_an_speed_100, i_an_full_duplex} = 2'($urandom);
      w = (k == 0) ? 16'h7DFF : (k == 1) ? 16'h0000 : 16'($urandom) & 16'h7DFF;
      wr(5'h00, w);
      rchk("control", 5'h00, w & 16'h7D81);
      chk("outputs", {6'h00, w[14], w[12], w[11], w[10], w[7], w[0], w[12] ? i_an_speed_100 : w[13],
        w[12] ? i_an_full_duplex : w[8], !w[11], 1'b0}, {6'h00, o_loopback, o_autoneg_enable, o_power_down,
        o_isolate, o_col_test, o_tx_disable, o_speed_100, o_full_duplex, o_core_enable, 1'b0});
    end
    pmb_station_i.half = 4;
    $display("test control done");
    wr(5'h00, 16'h1000);
    wr(5'h00, 16'h1200);
    rchk("control", 5'h00, 16'h1000);
    wr(5'h00, 16'h0000);
    wr(5'h00, 16'h0200);
    chk("restarts", 16'h0001, 16'(rscnt));
    wr(5'h00, 16'h4C81);
    wr(5'h00, 16'h8000);
    rchk("control", 5'h00, ctl_def());
    chk("reset span", 16'h0004, 16'(srcnt));
    $display("test self clearing done");
    foreach (rsv[i]) begin
      wr(rsv[i], 16'hFFFF);
      rchk("reserved", rsv[i], 16'h0000);
    end
    wr(5'h02, 16'h0000);
    rchk("ident", 5'h02, ID);
    foreach (fwd[i]) begin
      w = 16'($urandom);
      i_ext_rdata = 16'($urandom);
      wr(fwd[i], w);
      chk("ext addr", {11'h000, fwd[i]}, {11'h000, o_ext_addr});
      chk("ext data", w, o_ext_wdata);
      rchk("forwarded", fwd[i], i_ext_rdata);
    end
    chk("ext pulses", 16'h0808, {8'(wcnt), 8'(rcnt)});
    $display("test address map done");
    pmb_station_i.frame(2'b10, i_phy_addr ^ 5'h01, 5'h02, 16'h0000, r);
    chk("foreign read", 16'hFFFF, r);
    pmb_station_i.frame(2'b01, i_phy_addr ^ 5'h01, 5'h00, 16'h0800, r);
    pmb_station_i.frame(2'b11, i_phy_addr, 5'h00, 16'h0800, r);
    rchk("control", 5'h00, ctl_def());
    $display("test refused frames done");
    finish_test;
  end
endmodule
`default_nettype wire
